// ==== common/serial_port_pkg.sv ====
// Shared constants and types for the dual mode serial host port
package serial_port_pkg;

   // ----------------------------------------
   // Link widths and bit positions
   // ----------------------------------------
   localparam int           ADDR_BITS       = 7;
   localparam int           DATA_BITS       = 8;
   localparam logic [3:0]   I2C_BYTE_DONE   = 4'h8;
   localparam logic [3:0]   I2C_FIRST_SENT  = 4'h1;
   localparam logic [3:0]   SPI_ADDR_LAST   = 4'h6;
   localparam logic [3:0]   SPI_DIR_POS     = 4'h7;
   localparam logic [3:0]   SPI_DATA_FIRST  = 4'h8;
   localparam logic [3:0]   SPI_DATA_LAST   = 4'hF;

   // ----------------------------------------
   // Addresses and encodings
   // ----------------------------------------
   localparam logic [6:0]   I2C_ADDR_STRAP_LOW  = 7'h20;
   localparam logic [6:0]   I2C_ADDR_STRAP_HIGH = 7'h21;
   localparam logic         I2C_DIR_READ        = 1'b1;
   localparam logic         I2C_ACK_LEVEL       = 1'b0;
   localparam logic         SPI_DIR_WRITE       = 1'b1;
   localparam logic         IF_SEL_I2C          = 1'b0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0]   RST_COUNT = 4'h0;
   localparam logic [6:0]   RST_ADDR  = 7'h00;
   localparam logic [7:0]   RST_BYTE  = 8'h00;

   // ----------------------------------------
   // Two-wire slave states
   // ----------------------------------------
   typedef enum logic [3:0] {
      I2C_IDLE     = 4'h0,
      I2C_ADDR     = 4'h1,
      I2C_ACK_ADDR = 4'h2,
      I2C_REG      = 4'h3,
      I2C_ACK_REG  = 4'h4,
      I2C_WDATA    = 4'h5,
      I2C_ACK_DATA = 4'h6,
      I2C_SEND     = 4'h7,
      I2C_MACK     = 4'h8
   } i2c_state_t;

endpackage

// ==== hw/bit_sync.sv ====
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t s;
   sync_t next_s;

   always_comb begin
      next_s    = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.s2;

endmodule

// ==== hw/spi_link.sv ====
// Four-wire slave shifter running on the host serial clock
`timescale 1ns/100ps
module spi_link (
   input  wire logic       sck,
   input  wire logic       rstn,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   input  wire logic [7:0] rd_word,
   output logic            miso_o,
   output logic            miso_oe,
   output logic            evt_tog,
   output logic            evt_wr,
   output logic      [6:0] evt_addr,
   output logic      [7:0] evt_data
);

   typedef struct packed {
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [6:0] addr;
      logic       wr;
   } link_t;

   typedef struct packed {
      logic       tog;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } evt_t;

   typedef struct packed {
      logic [7:0] out;
      logic       oe;
   } drv_t;

   link_t l;
   link_t next_l;
   evt_t  e;
   evt_t  next_e;
   drv_t  d;
   drv_t  next_d;
   logic  link_rst_n;

   assign link_rst_n = rstn & ~ss_n;

   // ----------------------------------------
   // Rising edge capture
   // ----------------------------------------
   always_comb begin
      next_l = l;
      next_e = e;
      next_l.sh = {l.sh[6:0], mosi};
      if (l.cnt == serial_port_pkg::SPI_ADDR_LAST) begin
         next_l.addr = {l.sh[5:0], mosi};
         next_e.tog  = ~e.tog;
         next_e.wr   = 1'b0;
         next_e.addr = {l.sh[5:0], mosi};
      end
      if (l.cnt == serial_port_pkg::SPI_DIR_POS) begin
         next_l.wr = (mosi == serial_port_pkg::SPI_DIR_WRITE);
      end
      if (l.cnt == serial_port_pkg::SPI_DATA_FIRST && !l.wr) begin
         next_e.tog  = ~e.tog;
         next_e.wr   = 1'b0;
         next_e.addr = 7'(l.addr + 7'h01);
      end
      if (l.cnt == serial_port_pkg::SPI_DATA_LAST) begin
         if (l.wr) begin
            next_e.tog  = ~e.tog;
            next_e.wr   = 1'b1;
            next_e.addr = l.addr;
            next_e.data = {l.sh[6:0], mosi};
         end
         next_l.addr = 7'(l.addr + 7'h01);
         next_l.cnt  = serial_port_pkg::SPI_DATA_FIRST;
      end else begin
         next_l.cnt = 4'(l.cnt + 4'h1);
      end
   end

   // ----------------------------------------
   // Falling edge drive
   // ----------------------------------------
   always_comb begin
      next_d = d;
      if (l.cnt == serial_port_pkg::SPI_DATA_FIRST) begin
         next_d.out = rd_word;
         next_d.oe  = ~l.wr;
      end else if (l.cnt > serial_port_pkg::SPI_DATA_FIRST) begin
         next_d.out = {d.out[6:0], 1'b0};
      end
   end

   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         e <= '0;
      end else begin
         e <= next_e;
      end
   end

   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         d <= '0;
      end else begin
         d <= next_d;
      end
   end

   assign miso_o   = d.out[7];
   assign miso_oe  = d.oe;
   assign evt_tog  = e.tog;
   assign evt_wr   = e.wr;
   assign evt_addr = e.addr;
   assign evt_data = e.data;

endmodule

// ==== hw/dual_mode_serial_host_port.sv ====
// Dual mode serial host port: two-wire slave, four-wire slave, register access port
`timescale 1ns/100ps
module dual_mode_serial_host_port (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       if_sel,
   input  wire logic       addr_sel,
   input  wire logic       scl,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       sck,
   input  wire logic       ss_n,
   input  wire logic       mosi,
   output logic            miso_o,
   output logic            miso_oe,
   output logic      [6:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   output logic            bus_busy
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      serial_port_pkg::i2c_state_t st;
      logic [3:0]                  cnt;
      logic [7:0]                  sh;
      logic [7:0]                  tx;
      logic [6:0]                  ptr;
      logic                        rw;
      logic                        oe;
      logic                        scl_d;
      logic                        sda_d;
      logic                        busy;
      logic                        mode_spi;
      logic                        tog_d;
      logic                        rd_pend;
      logic                        wr;
      logic                        rd;
      logic [6:0]                  addr;
      logic [7:0]                  wdata;
      logic [7:0]                  spi_word;
   } port_t;

   port_t      s;
   port_t      next_s;
   logic       scl_s;
   logic       sda_s;
   logic       if_sel_s;
   logic       addr_sel_s;
   logic       tog_s;
   logic       spi_tog;
   logic       spi_wr;
   logic [6:0] spi_addr;
   logic [7:0] spi_data;
   logic       spi_oe;
   logic       start;
   logic       stop;
   logic       rise;
   logic       fall;
   logic [6:0] own_addr;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   bit_sync #(
      .W (5)
   ) u_sync (
      .clk  (sys_clk),
      .rstn (rstn),
      .d    ({scl, sda_i, if_sel, addr_sel, spi_tog}),
      .q    ({scl_s, sda_s, if_sel_s, addr_sel_s, tog_s})
   );

   // ----------------------------------------
   // Four-wire link on the host clock
   // ----------------------------------------
   spi_link u_spi (
      .sck      (sck),
      .rstn     (rstn),
      .ss_n     (ss_n),
      .mosi     (mosi),
      .rd_word  (s.spi_word),
      .miso_o   (miso_o),
      .miso_oe  (spi_oe),
      .evt_tog  (spi_tog),
      .evt_wr   (spi_wr),
      .evt_addr (spi_addr),
      .evt_data (spi_data)
   );

   // ----------------------------------------
   // Line events
   // ----------------------------------------
   always_comb begin
      start = s.scl_d & scl_s & s.sda_d & ~sda_s;
      stop  = s.scl_d & scl_s & ~s.sda_d & sda_s;
      // data sampled on clock edges only
      rise  = ~s.scl_d & scl_s;
      fall  = s.scl_d & ~scl_s;
      own_addr = addr_sel_s ? serial_port_pkg::I2C_ADDR_STRAP_HIGH : serial_port_pkg::I2C_ADDR_STRAP_LOW;
   end

   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   always_comb begin
      next_s          = s;
      next_s.wr       = 1'b0;
      next_s.rd       = 1'b0;
      next_s.scl_d    = scl_s;
      next_s.sda_d    = sda_s;
      next_s.tog_d    = tog_s;
      next_s.mode_spi = (if_sel_s != serial_port_pkg::IF_SEL_I2C);

      // Read data lands one cycle after the strobe
      if (s.rd_pend) begin
         next_s.rd_pend = 1'b0;
         if (s.mode_spi) begin
            next_s.spi_word = reg_rdata;
         end else begin
            next_s.tx = reg_rdata;
         end
      end

      if (s.mode_spi) begin
         next_s.st   = serial_port_pkg::I2C_IDLE;
         next_s.oe   = 1'b0;
         next_s.busy = 1'b0;
         if (tog_s != s.tog_d) begin
            next_s.addr  = spi_addr;
            next_s.wdata = spi_data;
            if (spi_wr) begin
               next_s.wr = 1'b1;
            end else begin
               next_s.rd      = 1'b1;
               next_s.rd_pend = 1'b1;
            end
         end
      end else if (start) begin
         next_s.st   = serial_port_pkg::I2C_ADDR;
         next_s.cnt  = serial_port_pkg::RST_COUNT;
         next_s.oe   = 1'b0;
         next_s.busy = 1'b1;
      end else if (stop) begin
         next_s.st   = serial_port_pkg::I2C_IDLE;
         next_s.oe   = 1'b0;
         next_s.busy = 1'b0;
      end else begin
         unique case (s.st)
            serial_port_pkg::I2C_IDLE: begin
               next_s.oe = 1'b0;
            end
            serial_port_pkg::I2C_ADDR,
            serial_port_pkg::I2C_REG,
            serial_port_pkg::I2C_WDATA: begin
               if (rise && s.cnt < serial_port_pkg::I2C_BYTE_DONE) begin
                  next_s.sh  = {s.sh[6:0], sda_s};
                  next_s.cnt = 4'(s.cnt + 4'h1);
               end else if (fall && s.cnt == serial_port_pkg::I2C_BYTE_DONE) begin
                  next_s.cnt = serial_port_pkg::RST_COUNT;
                  if (s.st == serial_port_pkg::I2C_ADDR) begin
                     if (s.sh[7:1] == own_addr) begin
                        next_s.oe = 1'b1;
                        next_s.rw = (s.sh[0] == serial_port_pkg::I2C_DIR_READ);
                        next_s.st = serial_port_pkg::I2C_ACK_ADDR;
                     end else begin
                        next_s.oe = 1'b0;
                        next_s.st = serial_port_pkg::I2C_IDLE;
                     end
                  end else if (s.st == serial_port_pkg::I2C_REG) begin
                     next_s.ptr = s.sh[6:0];
                     next_s.oe  = 1'b1;
                     next_s.st  = serial_port_pkg::I2C_ACK_REG;
                  end else begin
                     next_s.wr    = 1'b1;
                     next_s.addr  = s.ptr;
                     next_s.wdata = s.sh;
                     next_s.oe    = 1'b1;
                     next_s.st    = serial_port_pkg::I2C_ACK_DATA;
                  end
               end
            end
            serial_port_pkg::I2C_ACK_ADDR: begin
               // fetch from address set by earlier write
               if (rise && s.rw) begin
                  next_s.rd      = 1'b1;
                  next_s.addr    = s.ptr;
                  next_s.rd_pend = 1'b1;
               end
               if (fall) begin
                  if (s.rw) begin
                     next_s.sh  = s.tx;
                     next_s.oe  = ~s.tx[7];
                     next_s.cnt = serial_port_pkg::I2C_FIRST_SENT;
                     next_s.st  = serial_port_pkg::I2C_SEND;
                  end else begin
                     next_s.oe  = 1'b0;
                     next_s.cnt = serial_port_pkg::RST_COUNT;
                     next_s.st  = serial_port_pkg::I2C_REG;
                  end
               end
            end
            serial_port_pkg::I2C_ACK_REG: begin
               if (fall) begin
                  next_s.oe = 1'b0;
                  next_s.st = serial_port_pkg::I2C_WDATA;
               end
            end
            serial_port_pkg::I2C_ACK_DATA: begin
               if (fall) begin
                  next_s.oe  = 1'b0;
                  next_s.ptr = 7'(s.ptr + 7'h01);
                  next_s.st  = serial_port_pkg::I2C_WDATA;
               end
            end
            serial_port_pkg::I2C_SEND: begin
               if (fall) begin
                  if (s.cnt < serial_port_pkg::I2C_BYTE_DONE) begin
                     next_s.sh  = {s.sh[6:0], 1'b0};
                     next_s.oe  = ~s.sh[6];
                     next_s.cnt = 4'(s.cnt + 4'h1);
                  end else begin
                     next_s.oe  = 1'b0;
                     next_s.ptr = 7'(s.ptr + 7'h01);
                     next_s.st  = serial_port_pkg::I2C_MACK;
                  end
               end
            end
            serial_port_pkg::I2C_MACK: begin
               if (rise) begin
                  if (sda_s == serial_port_pkg::I2C_ACK_LEVEL) begin
                     next_s.rd      = 1'b1;
                     next_s.addr    = s.ptr;
                     next_s.rd_pend = 1'b1;
                     next_s.rw      = 1'b1;
                     next_s.st      = serial_port_pkg::I2C_ACK_ADDR;
                  end else begin
                     next_s.st = serial_port_pkg::I2C_IDLE;
                  end
               end
            end
            default: begin
               next_s.st = serial_port_pkg::I2C_IDLE;
               next_s.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s       <= '0;
         s.scl_d <= 1'b1;
         s.sda_d <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sda_o     = 1'b0;
   assign sda_oe    = s.oe & ~s.mode_spi;
   assign miso_oe   = spi_oe & s.mode_spi;
   assign reg_addr  = s.addr;
   assign reg_wdata = s.wdata;
   assign reg_wr    = s.wr;
   assign reg_rd    = s.rd;
   assign bus_busy  = s.busy;

endmodule

// ==== tb/serial_port_asserts.sv ====
// Concurrent checks on the serial host port pins
`timescale 1ns/100ps
module serial_port_asserts (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic if_sel,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_oe,
   input wire logic sck,
   input wire logic ss_n,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic bus_busy
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   reset_quiet_a: assert property (disable iff (1'b0) !rstn |-> !sda_oe && !miso_oe && !reg_wr && !bus_busy)
      else $error("outputs active in reset");
   i2c_muted_a: assert property (if_sel [*5] |-> !sda_oe)
      else $error("data line driven in four-wire mode");
   spi_muted_a: assert property (!if_sel [*5] |-> !miso_oe)
      else $error("serial output driven in two-wire mode");
   sel_release_a: assert property (ss_n |-> !miso_oe)
      else $error("serial output driven while deselected");
   miso_edge_a: assert property (!ss_n && !$past(ss_n) && $changed(miso_o) |-> !sck)
      else $error("serial output moved on rising clock");
   oe_edge_a: assert property ($rose(miso_oe) |-> !sck && !ss_n)
      else $error("serial output enabled off the falling clock");
   sda_low_a: assert property ($changed(sda_oe) |-> !scl)
      else $error("data line moved while clock high");
   start_busy_a: assert property (!if_sel && scl && $past(scl) && $fell(sda_i) |-> ##[1:6] bus_busy)
      else $error("start did not mark bus busy");
   stop_free_a: assert property (!if_sel && scl && $past(scl) && $rose(sda_i) |-> ##[1:6] !bus_busy)
      else $error("stop did not free bus");
   wr_pulse_a: assert property (reg_wr |=> !reg_wr ##1 !reg_wr)
      else $error("write strobe longer than one cycle");

   cover property (reg_wr && !if_sel);
   cover property (reg_rd && if_sel);
   cover property ($fell(bus_busy));
endmodule

// ==== tb/host_master_model.sv ====
// Host master model driving the two-wire and four-wire links
`timescale 1ns/100ps
module host_master_model (
   input  wire logic clk,
   input  wire logic sda,
   input  wire logic miso_o,
   input  wire logic miso_oe,
   output logic      scl,
   output logic      sda_low,
   output logic      sck,
   output logic      ss_n,
   output logic      mosi
);
   // ----------------------------------------
   // Link tasks
   // ----------------------------------------
   localparam realtime Q = 96;
   localparam realtime H = 15;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      sck = 1'b0;
      ss_n = 1'b0;
      mosi = 1'b0;
      // Deselect only after the reset edge so the link logic is cleared
      #2 ss_n = 1'b1;
   end

   task automatic i2c_start();
      @(posedge clk) #1;
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask

   task automatic i2c_stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask

   // bits on low clock, msb first
   task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         #Q sda_low = (i > 0) ? !tx[i-1] : mack;
         #Q scl = 1'b1;
         #Q;
         if (i > 0) rx[i-1] = sda;
         else ack = sda;
         #Q scl = 1'b0;
      end
   endtask

   task automatic spi_frame(input logic [23:0] v, input int n, output logic [15:0] q);
      @(posedge clk) #1;
      #3.7 ss_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi = v[23-i];
         #H sck = 1'b1;
         q = {q[14:0], miso_oe ? miso_o : 1'bx};
         #H sck = 1'b0;
      end
      #H ss_n = 1'b1;
      mosi = !mosi;
   endtask
endmodule

// ==== tb/tb_dual_mode_serial_host_port.sv ====
// Self-checking bench for the dual mode serial host port
`timescale 1ns/100ps
module tb_dual_mode_serial_host_port;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b1;
   logic        if_sel = 1'b0;
   logic        addr_sel = 1'b0;
   logic        scl, sda_low, sda_o, sda_oe, sck, ss_n, mosi, miso_o, miso_oe;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rx;
   logic [7:0]  mem [128];
   logic        reg_wr, reg_rd, bus_busy, ack;
   logic [15:0] q;
   int          bad_count = 0, check_count = 0, wr_count = 0, rd_count = 0, cyc = 0;
   wire         sda = (sda_oe ? sda_o : 1'b1) && !sda_low;

   assign reg_rdata = mem[reg_addr];
   always #4 sys_clk = !sys_clk;

   dual_mode_serial_host_port i_dut (.sys_clk, .rstn, .if_sel, .addr_sel, .scl, .sda_i(sda), .sda_o, .sda_oe,
      .sck, .ss_n, .mosi, .miso_o, .miso_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_busy);
   host_master_model i_host (.clk(sys_clk), .sda, .miso_o, .miso_oe, .scl, .sda_low, .sck, .ss_n, .mosi);

   // ----------------------------------------
   // Register file, timeout, checks
   // ----------------------------------------
   always @(posedge sys_clk) if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
   end

   always @(posedge sys_clk) if (reg_rd) begin
      rd_count <= rd_count + 1;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wb(input logic [7:0] b, input logic exp);
      i_host.i2c_byte(b, 1'b0, rx, ack);
      check(ack, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_i2c_write();
      int n;
      n = wr_count;
      i_host.i2c_start();
      wb(8'h40, 1'b0);
      wb(8'h10, 1'b0);
      wb(8'h3C, 1'b0);
      wb(8'hC5, 1'b0);
      check(bus_busy, 1'b1);
      i_host.i2c_stop();
      check(mem[7'h10], 8'h3C);
      check(mem[7'h11], 8'hC5);
      check(16'(wr_count - n), 16'h0002);
      check(bus_busy, 1'b0);
   endtask

   task automatic t_i2c_read();
      int n;
      n = rd_count;
      addr_sel = 1'b1;
      idle(6);
      i_host.i2c_start();
      wb(8'h42, 1'b0);
      wb(8'h10, 1'b0);
      i_host.i2c_start();
      wb(8'h43, 1'b0);
      i_host.i2c_byte(8'hFF, 1'b1, rx, ack);
      check(rx, 8'h3C);
      i_host.i2c_byte(8'hFF, 1'b0, rx, ack);
      check(rx, 8'hC5);
      i_host.i2c_stop();
      check(16'(rd_count - n), 16'h0002);
   endtask

   task automatic t_refuse();
      int n;
      n = wr_count;
      i_host.i2c_start();
      wb(8'h40, 1'b1);
      i_host.i2c_stop();
      addr_sel = 1'b0;
      idle(6);
      i_host.i2c_start();
      wb(8'h44, 1'b1);
      wb(8'h10, 1'b1);
      i_host.i2c_stop();
      check(16'(wr_count - n), 16'h0000);
   endtask

   task automatic t_spi_write();
      if_sel = 1'b1;
      idle(8);
      i_host.spi_frame({7'h05, 1'b1, 16'h5AA6}, 24, q);
      idle(10);
      check(mem[7'h05], 8'h5A);
      check(mem[7'h06], 8'hA6);
   endtask

   task automatic t_spi_read();
      int n;
      int m;
      n = wr_count;
      m = rd_count;
      i_host.spi_frame({7'h05, 1'b0, 16'hFFFF}, 24, q);
      idle(10);
      check(q, 16'h5AA6);
      check(16'(wr_count - n), 16'h0000);
      check(16'(rd_count - m), 16'h0003);
   endtask

   task automatic t_spi_abort();
      i_host.spi_frame({7'h07, 1'b1, 16'h3300}, 12, q);
      i_host.spi_frame({7'h08, 1'b1, 16'h9900}, 16, q);
      idle(10);
      check(mem[7'h07], 8'h00);
      check(mem[7'h08], 8'h99);
   endtask

   task automatic t_mode();
      i_host.i2c_start();
      wb(8'h40, 1'b1);
      i_host.i2c_stop();
      if_sel = 1'b0;
      idle(8);
      i_host.spi_frame({7'h09, 1'b1, 16'h7700}, 16, q);
      idle(10);
      check(mem[7'h09], 8'h00);
   endtask

   initial begin
      mem = '{default: 8'h00};
      #1 rstn = 1'b0;
      idle(4);
      rstn = 1'b1;
      idle(8);
      t_i2c_write();
      t_i2c_read();
      t_refuse();
      t_spi_write();
      t_spi_read();
      t_spi_abort();
      t_mode();
      wrap_up();
   end
endmodule

bind dual_mode_serial_host_port serial_port_asserts i_chk (.sys_clk, .rstn, .if_sel, .scl, .sda_i, .sda_oe, .sck,
   .ss_n, .miso_o, .miso_oe, .reg_wr, .reg_rd, .bus_busy);
